// ### serial_rtc_regs.vh
// register indices, field positions, reset values and timing counts of the serial clock/ram block
`ifndef SERIAL_RTC_REGS_VH
`define SERIAL_RTC_REGS_VH

// clock space register indices
`define RTC_IDX_SECONDS    5'd0
`define RTC_IDX_MINUTES    5'd1
`define RTC_IDX_HOURS      5'd2
`define RTC_IDX_DATE       5'd3
`define RTC_IDX_MONTH      5'd4
`define RTC_IDX_DAY        5'd5
`define RTC_IDX_YEAR       5'd6
`define RTC_IDX_CONTROL    5'd7
`define RTC_IDX_CHARGER    5'd8
`define RTC_IDX_BURST      5'd31
`define RTC_IDX_RAM_LAST   5'd30
`define RTC_IDX_CLK_LAST   5'd7

// command byte fields
`define RTC_CMD_VALID_BIT  7
`define RTC_CMD_SPACE_BIT  6
`define RTC_CMD_IDX_HI     5
`define RTC_CMD_IDX_LO     1
`define RTC_CMD_READ_BIT   0

// data fields
`define RTC_SEC_HALT_BIT   7
`define RTC_HOUR_12H_BIT   7
`define RTC_HOUR_PM_BIT    5
`define RTC_CTRL_WP_BIT    7
`define RTC_CHARGE_KEY     4'hA
`define RTC_DIODE_ONE      2'b01
`define RTC_DIODE_TWO      2'b10
`define RTC_RES_NONE       2'b00

// burst lengths
`define RTC_CLK_BURST_LEN  4'd8
`define RTC_RAM_DEPTH      31

// reset values
`define RTC_RST_SECONDS    8'h80
`define RTC_RST_MINUTES    8'h00
`define RTC_RST_HOURS      8'h00
`define RTC_RST_DATE       8'h01
`define RTC_RST_MONTH      8'h01
`define RTC_RST_DAY        8'h01
`define RTC_RST_YEAR       8'h00
`define RTC_RST_CONTROL    8'h80
`define RTC_RST_CHARGER    8'h5C

// timing: oscillator rate and seconds tick period
`define RTC_OSC_HZ         32768
`define RTC_TICK_S         1
`define RTC_OSC_DIV        (`RTC_OSC_HZ * `RTC_TICK_S)

`endif

// ### rtc_timekeeper.v
// bcd time and calendar counters with the one-hertz divider
`timescale 1ns/10ps
`include "serial_rtc_regs.vh"
module rtc_timekeeper #(
  parameter OSC_DIV = `RTC_OSC_DIV,
  parameter DIV_W   = 16
) (
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire        osc_pulse,
  input  wire [6:0]  load_mask,
  input  wire [55:0] load_data,
  output wire [55:0] time_now,
  output wire        halted
);

localparam integer     DIV_LAST_I = OSC_DIV - 1;
localparam [DIV_W-1:0] DIV_LAST   = DIV_LAST_I[DIV_W-1:0];

reg  [7:0]       sec_ff;
reg  [7:0]       min_ff;
reg  [7:0]       hour_ff;
reg  [7:0]       date_ff;
reg  [7:0]       month_ff;
reg  [7:0]       day_ff;
reg  [7:0]       year_ff;
reg  [DIV_W-1:0] div_ff;
reg  [7:0]       nxt_sec;
reg  [7:0]       nxt_min;
reg  [7:0]       nxt_hour;
reg  [7:0]       nxt_date;
reg  [7:0]       nxt_month;
reg  [7:0]       nxt_day;
reg  [7:0]       nxt_year;
reg  [7:0]       max_date;
reg              leap;
reg              c_min;
reg              c_hour;
reg              c_day;
reg              c_month;
reg              c_year;
wire             tick;

function [7:0] inc_bcd;
  input [7:0] v;
  begin
    inc_bcd = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  end
endfunction

assign halted   = sec_ff[`RTC_SEC_HALT_BIT];
assign time_now = {year_ff, day_ff, month_ff, date_ff, hour_ff, min_ff, sec_ff};
// halt stops the divider and every counter
assign tick     = osc_pulse & ~halted & (div_ff == DIV_LAST);

////////////////////////////////////////////////////////////////////////////////
always @* begin
  leap     = year_ff[4] ? (year_ff[3:0] == 4'h2 || year_ff[3:0] == 4'h6)
                        : (year_ff[3:0] == 4'h0 || year_ff[3:0] == 4'h4 || year_ff[3:0] == 4'h8);
  max_date = (month_ff == 8'h02) ? (leap ? 8'h29 : 8'h28) :
             (month_ff == 8'h04 || month_ff == 8'h06 || month_ff == 8'h09 || month_ff == 8'h11) ? 8'h30 : 8'h31;
  // bcd counting throughout
  c_min    = (sec_ff[6:0] == 7'h59);
  nxt_sec  = c_min ? {sec_ff[7], 7'h00} : ({sec_ff[7], 7'h00} | (inc_bcd({1'b0, sec_ff[6:0]}) & 8'h7F));
  c_hour   = c_min & (min_ff == 8'h59);
  nxt_min  = (min_ff == 8'h59) ? 8'h00 : inc_bcd(min_ff);
  if (hour_ff[`RTC_HOUR_12H_BIT]) begin
    c_day = 1'b0;
    if (hour_ff[4:0] == 5'h11) begin
      nxt_hour = {hour_ff[7:6], ~hour_ff[`RTC_HOUR_PM_BIT], 5'h12};
      c_day    = hour_ff[`RTC_HOUR_PM_BIT];
    end else if (hour_ff[4:0] == 5'h12) begin
      nxt_hour = {hour_ff[7:5], 5'h01};
    end else begin
      nxt_hour = {hour_ff[7:5], 5'h00} | (inc_bcd({3'b000, hour_ff[4:0]}) & 8'h1F);
    end
  end else begin
    c_day    = (hour_ff[5:0] == 6'h23);
    nxt_hour = c_day ? {hour_ff[7:6], 6'h00} : {hour_ff[7:6], 6'h00} | (inc_bcd({2'b00, hour_ff[5:0]}) & 8'h3F);
  end
  c_day     = c_day & c_hour;
  c_month   = c_day & (date_ff == max_date);
  nxt_date  = (date_ff == max_date) ? 8'h01 : inc_bcd(date_ff);
  nxt_day   = (day_ff == 8'h07) ? 8'h01 : inc_bcd(day_ff);
  c_year    = c_month & (month_ff == 8'h12);
  nxt_month = (month_ff == 8'h12) ? 8'h01 : inc_bcd(month_ff);
  nxt_year  = (year_ff == 8'h99) ? 8'h00 : inc_bcd(year_ff);
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk or negedge reset_n) begin
  if (!reset_n) begin
    div_ff   <= {DIV_W{1'b0}};
    sec_ff   <= `RTC_RST_SECONDS;
    min_ff   <= `RTC_RST_MINUTES;
    hour_ff  <= `RTC_RST_HOURS;
    date_ff  <= `RTC_RST_DATE;
    month_ff <= `RTC_RST_MONTH;
    day_ff   <= `RTC_RST_DAY;
    year_ff  <= `RTC_RST_YEAR;
  end else begin
    // a seconds write restarts the sub-second chain
    if (load_mask[0])
      div_ff <= {DIV_W{1'b0}};
    else if (osc_pulse & ~halted)
      div_ff <= (div_ff == DIV_LAST) ? {DIV_W{1'b0}} : div_ff + 1'b1;
    if (load_mask[0])      sec_ff   <= load_data[7:0];
    else if (tick)         sec_ff   <= nxt_sec;
    if (load_mask[1])      min_ff   <= load_data[15:8];
    else if (tick & c_min) min_ff   <= nxt_min;
    if (load_mask[2])      hour_ff  <= load_data[23:16];
    else if (tick & c_hour) hour_ff <= nxt_hour;
    if (load_mask[3])      date_ff  <= load_data[31:24];
    else if (tick & c_day) date_ff  <= nxt_date;
    if (load_mask[4])      month_ff <= load_data[39:32];
    else if (tick & c_month) month_ff <= nxt_month;
    if (load_mask[5])      day_ff   <= load_data[47:40];
    else if (tick & c_day) day_ff   <= nxt_day;
    if (load_mask[6])      year_ff  <= load_data[55:48];
    else if (tick & c_year) year_ff <= nxt_year;
  end
end

endmodule // rtc_timekeeper

// ### serial_rtc_ram_3wire.v
// 3-wire serial port, snapshot, staging, ram and charger selection of the serial clock/ram block
//
// Behaviour
// - command bit 7 zero forbids any write
// - bit6 space, bits5:1 index, bit0 read
// - command byte arrives lsb first
// - chip enable low aborts and releases data
// - sample on rising, launch on falling
// - write takes one byte, extra cycles ignored
// - read drives from next falling edge, lsb first
// - continued shifting keeps reading bytes out
// - index 31 is burst from index zero
// - clock burst commits only after eight bytes
// - ram burst stores every complete byte
// - time registers hold and count bcd
// - weekday advances at midnight through 1..7
// - enable rise snapshots time for reads
// - time writes commit at enable fall
// - hours bit7 selects 12h with pm bit5
// - seconds bit7 halts the clock
// - protect bit blocks other writes, reads zeros
// - protected clock burst changes nothing
// - charger on only with key and valid fields
// - diode and resistor field decode
`timescale 1ns/10ps
`include "serial_rtc_regs.vh"
module serial_rtc_ram_3wire #(
  parameter OSC_DIV = `RTC_OSC_DIV
) (
  input  wire       sys_clk,
  input  wire       reset_n,
  input  wire       ce,
  input  wire       sclk,
  input  wire       io_in,
  input  wire       osc_in,
  output wire       io_out,
  output wire       io_oe,
  output wire       charger_enable,
  output wire       charger_two_diodes,
  output wire [1:0] charger_resistor,
  output wire       osc_running
);

localparam [4:0] ST_CMD    = 5'b00001;
localparam [4:0] ST_WDATA  = 5'b00010;
localparam [4:0] ST_RDATA  = 5'b00100;
localparam [4:0] ST_IGNORE = 5'b01000;
localparam [4:0] ST_OFF    = 5'b10000;
localparam [7:0] RST_CTRL  = `RTC_RST_CONTROL;

reg  [3:0]  pin_meta_ff;
reg  [3:0]  pin_sync_ff;
reg  [3:0]  pin_last_ff;
reg  [4:0]  state_ff;
reg  [2:0]  bit_cnt_ff;
reg  [7:0]  shift_ff;
reg         space_ram_ff;
reg         burst_ff;
reg  [4:0]  idx_ff;
reg         burst_block_ff;
reg  [3:0]  burst_cnt_ff;
reg  [55:0] snap_ff;
reg  [55:0] stage_ff;
reg  [6:0]  stage_mask_ff;
reg  [7:0]  ctrl_stage_ff;
reg  [6:0]  load_mask_ff;
reg         wp_ff;
reg  [7:0]  charger_ff;
reg         io_out_ff;
reg         io_oe_ff;
reg         charger_enable_ff;
reg         charger_two_ff;
reg  [1:0]  charger_res_ff;
reg  [7:0]  ram_ff [0:`RTC_RAM_DEPTH-1];
reg  [7:0]  read_byte;
wire        ce_s;
wire        ce_rise;
wire        ce_fall;
wire        sclk_rise;
wire        sclk_fall;
wire        io_s;
wire        osc_pulse;
wire [7:0]  in_byte;
wire        byte_done;
wire        ram_we;
wire [55:0] time_now;
wire        halted;

assign io_out             = io_out_ff;
assign io_oe              = io_oe_ff;
assign charger_enable     = charger_enable_ff;
assign charger_two_diodes = charger_two_ff;
assign charger_resistor   = charger_res_ff;
assign osc_running        = ~halted;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: bit0 enable, bit1 shift clock, bit2 data, bit3 oscillator
genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : g_sync
    always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        pin_meta_ff[g] <= 1'b0;
        pin_sync_ff[g] <= 1'b0;
        pin_last_ff[g] <= 1'b0;
      end else begin
        pin_meta_ff[g] <= (g == 0) ? ce : (g == 1) ? sclk : (g == 2) ? io_in : osc_in;
        pin_sync_ff[g] <= pin_meta_ff[g];
        pin_last_ff[g] <= pin_sync_ff[g];
      end
    end
  end
endgenerate

assign ce_s      = pin_sync_ff[0];
assign ce_rise   = pin_sync_ff[0] & ~pin_last_ff[0];
assign ce_fall   = ~pin_sync_ff[0] & pin_last_ff[0];
// edges count only while enable is high; the host holds the clock low at the raise
assign sclk_rise = ce_s & pin_last_ff[0] & pin_sync_ff[1] & ~pin_last_ff[1];
assign sclk_fall = ce_s & pin_last_ff[0] & ~pin_sync_ff[1] & pin_last_ff[1];
assign io_s      = pin_sync_ff[2];
assign osc_pulse = pin_sync_ff[3] & ~pin_last_ff[3];

// serial bytes assemble lsb first
assign in_byte   = {io_s, shift_ff[7:1]};
assign byte_done = sclk_rise & (state_ff == ST_WDATA) & (bit_cnt_ff == 3'd7);
// ram bytes land as each one completes
assign ram_we    = byte_done & space_ram_ff & ~wp_ff & (idx_ff <= `RTC_IDX_RAM_LAST);

////////////////////////////////////////////////////////////////////////////////
// read data source: clock space time registers read the snapshot, control and charger read live values
always @* begin
  read_byte = 8'h00;
  if (space_ram_ff) begin
    if (idx_ff <= `RTC_IDX_RAM_LAST)
      read_byte = ram_ff[idx_ff];
  end else begin
    case (idx_ff)
      `RTC_IDX_SECONDS: read_byte = snap_ff[7:0];
      `RTC_IDX_MINUTES: read_byte = snap_ff[15:8];
      `RTC_IDX_HOURS:   read_byte = snap_ff[23:16];
      `RTC_IDX_DATE:    read_byte = snap_ff[31:24];
      `RTC_IDX_MONTH:   read_byte = snap_ff[39:32];
      `RTC_IDX_DAY:     read_byte = snap_ff[47:40];
      `RTC_IDX_YEAR:    read_byte = snap_ff[55:48];
      `RTC_IDX_CONTROL: read_byte = {wp_ff, 7'h00};
      `RTC_IDX_CHARGER: read_byte = burst_ff ? 8'h00 : charger_ff;
      default:          read_byte = 8'h00;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk) begin
  if (ram_we)
    ram_ff[idx_ff] <= in_byte;
end

////////////////////////////////////////////////////////////////////////////////
// serial transfer engine
always @(posedge sys_clk or negedge reset_n) begin
  if (!reset_n) begin
    state_ff       <= ST_OFF;
    bit_cnt_ff     <= 3'd0;
    shift_ff       <= 8'h00;
    space_ram_ff   <= 1'b0;
    burst_ff       <= 1'b0;
    idx_ff         <= 5'd0;
    burst_block_ff <= 1'b0;
    burst_cnt_ff   <= 4'd0;
    io_out_ff      <= 1'b0;
    io_oe_ff       <= 1'b0;
  end else if (!ce_s) begin
    // enable low ends everything and floats the data line
    state_ff   <= ST_OFF;
    bit_cnt_ff <= 3'd0;
    io_oe_ff   <= 1'b0;
  end else if (ce_rise) begin
    state_ff     <= ST_CMD;
    bit_cnt_ff   <= 3'd0;
    burst_cnt_ff <= 4'd0;
    burst_ff     <= 1'b0;
  end else begin
    if (sclk_rise) begin
      io_oe_ff <= 1'b0;
      shift_ff <= in_byte;
      if (state_ff == ST_CMD || state_ff == ST_WDATA)
        bit_cnt_ff <= bit_cnt_ff + 3'd1;
    end
    case (state_ff)
      ST_CMD: begin
        if (sclk_rise && bit_cnt_ff == 3'd7) begin
          // command decode
          space_ram_ff   <= in_byte[`RTC_CMD_SPACE_BIT];
          burst_ff       <= (in_byte[`RTC_CMD_IDX_HI:`RTC_CMD_IDX_LO] == `RTC_IDX_BURST);
          idx_ff         <= (in_byte[`RTC_CMD_IDX_HI:`RTC_CMD_IDX_LO] == `RTC_IDX_BURST) ? 5'd0
                            : in_byte[`RTC_CMD_IDX_HI:`RTC_CMD_IDX_LO];
          burst_block_ff <= wp_ff;
          if (in_byte[`RTC_CMD_READ_BIT])
            state_ff <= ST_RDATA;
          else if (in_byte[`RTC_CMD_VALID_BIT])
            state_ff <= ST_WDATA;
          else
            state_ff <= ST_IGNORE;
        end
      end
      ST_WDATA: begin
        if (byte_done) begin
          if (!burst_ff) begin
            state_ff <= ST_IGNORE;
          end else begin
            burst_cnt_ff <= burst_cnt_ff + 4'd1;
            idx_ff       <= idx_ff + 5'd1;
            if ((space_ram_ff && idx_ff == `RTC_IDX_RAM_LAST) ||
                (!space_ram_ff && idx_ff == `RTC_IDX_CLK_LAST))
              state_ff <= ST_IGNORE;
          end
        end
      end
      ST_RDATA: begin
        if (sclk_fall) begin
          // launch on falling edges, lsb first
          io_out_ff  <= read_byte[bit_cnt_ff];
          io_oe_ff   <= 1'b1;
          bit_cnt_ff <= bit_cnt_ff + 3'd1;
          if (bit_cnt_ff == 3'd7 && burst_ff) begin
            // keep streaming while the host keeps clocking
            if ((space_ram_ff && idx_ff == `RTC_IDX_RAM_LAST) ||
                (!space_ram_ff && idx_ff == `RTC_IDX_CLK_LAST))
              idx_ff <= 5'd0;
            else
              idx_ff <= idx_ff + 5'd1;
          end
        end
      end
      ST_IGNORE: begin
        bit_cnt_ff <= 3'd0;
      end
      ST_OFF: begin
        bit_cnt_ff <= 3'd0;
      end
      default: begin
        state_ff <= ST_OFF;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// time writes: staged while enable is high, committed at its fall; single control and charger writes act at once
always @(posedge sys_clk or negedge reset_n) begin
  if (!reset_n) begin
    stage_ff      <= 56'h0;
    stage_mask_ff <= 7'h00;
    ctrl_stage_ff <= 8'h00;
    load_mask_ff  <= 7'h00;
    wp_ff         <= RST_CTRL[`RTC_CTRL_WP_BIT];
    charger_ff    <= `RTC_RST_CHARGER;
    snap_ff       <= 56'h0;
  end else begin
    load_mask_ff <= 7'h00;
    if (ce_rise) begin
      snap_ff       <= time_now;
      stage_mask_ff <= 7'h00;
    end
    if (byte_done && !space_ram_ff) begin
      if (burst_ff) begin
        if (idx_ff == `RTC_IDX_CONTROL)
          ctrl_stage_ff <= in_byte;
        else begin
          stage_ff[{idx_ff[2:0], 3'b000} +: 8] <= in_byte;
          stage_mask_ff[idx_ff[2:0]]            <= 1'b1;
        end
      end else if (idx_ff == `RTC_IDX_CONTROL) begin
        wp_ff <= in_byte[`RTC_CTRL_WP_BIT];
      end else if (!wp_ff) begin
        if (idx_ff == `RTC_IDX_CHARGER)
          charger_ff <= in_byte;
        else if (idx_ff < `RTC_IDX_CONTROL) begin
          stage_ff[{idx_ff[2:0], 3'b000} +: 8] <= in_byte;
          stage_mask_ff[idx_ff[2:0]]            <= 1'b1;
        end
      end
    end
    if (ce_fall) begin
      stage_mask_ff <= 7'h00;
      if (burst_ff && !space_ram_ff) begin
        // all eight or nothing, and nothing while protected
        if (!burst_block_ff && burst_cnt_ff == `RTC_CLK_BURST_LEN) begin
          load_mask_ff <= 7'h7F;
          wp_ff        <= ctrl_stage_ff[`RTC_CTRL_WP_BIT];
        end
      end else begin
        load_mask_ff <= stage_mask_ff;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// charger decode
always @(posedge sys_clk or negedge reset_n) begin
  if (!reset_n) begin
    charger_enable_ff <= 1'b0;
    charger_two_ff    <= 1'b0;
    charger_res_ff    <= `RTC_RES_NONE;
  end else begin
    charger_enable_ff <= (charger_ff[7:4] == `RTC_CHARGE_KEY) &&
                         (charger_ff[3:2] == `RTC_DIODE_ONE || charger_ff[3:2] == `RTC_DIODE_TWO) &&
                         (charger_ff[1:0] != `RTC_RES_NONE);
    charger_two_ff    <= (charger_ff[3:2] == `RTC_DIODE_TWO);
    charger_res_ff    <= charger_ff[1:0];
  end
end

////////////////////////////////////////////////////////////////////////////////
rtc_timekeeper #(
  .OSC_DIV (OSC_DIV)
) u_timekeeper (
  .sys_clk   (sys_clk),
  .reset_n   (reset_n),
  .osc_pulse (osc_pulse),
  .load_mask (load_mask_ff),
  .load_data (stage_ff),
  .time_now  (time_now),
  .halted    (halted)
);

endmodule // serial_rtc_ram_3wire

// ### rtc_host_model.sv
// host model driving chip enable, shift clock and data of the 3-wire port
`timescale 1ns/10ps
module rtc_host_model (
  output logic ce,
  output logic sclk,
  output logic io_drv,
  output logic io_en,
  input  wire  io_line
);
  logic [63:0] rx;

  initial begin
    ce = 1'b0;
    sclk = 1'b0;
    io_drv = 1'b0;
    io_en = 1'b0;
    rx = 64'h0;
  end

  ////////////////////////////////////////////////////////////
  task automatic shift(input logic [7:0] b, input logic drv, output logic [7:0] r);
    for (int i = 0; i < 8; i++) begin
      io_en <= drv;
      io_drv <= b[i];
      #24 r[i] = io_line;
      sclk <= 1'b1;
      #24 sclk <= 1'b0;
    end
  endtask

  // released line falls to the pull-down level
  task automatic xfer(input logic [7:0] cmd, input int n, input logic [63:0] d);
    logic [7:0] r;
    ce <= 1'b1;
    shift(cmd, 1'b1, r);
    for (int k = 0; k < n; k++) begin
      shift(d[8*k +: 8], !cmd[0], r);
      rx[8*k +: 8] = r;
    end
    #24 ce <= 1'b0;
    io_en <= 1'b0;
    #48;
  endtask
endmodule // rtc_host_model

// ### rtc_port_properties.sv
// port assertions of the serial clock/ram block
`timescale 1ns/10ps
module rtc_port_checker (
  input wire       sys_clk,
  input wire       reset_n,
  input wire       ce,
  input wire       sclk,
  input wire       io_in,
  input wire       osc_in,
  input wire       io_out,
  input wire       io_oe,
  input wire       charger_enable,
  input wire       charger_two_diodes,
  input wire [1:0] charger_resistor,
  input wire       osc_running
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////
  property p_release_idle;
    !ce [*5] |-> !io_oe;
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("data driven with enable low");
  property p_oe_launch;
    $rose(io_oe) |-> !sclk && ce;
  endproperty
  a_oe_launch: assert property (p_oe_launch) else $error("drive began off a falling edge");
  property p_drop_on_rise;
    $rose(sclk) |-> ##[2:6] !io_oe;
  endproperty
  a_drop_on_rise: assert property (p_drop_on_rise) else $error("line kept after rising edge");
  property p_stable_bit;
    io_oe && $past(io_oe) |-> $stable(io_out);
  endproperty
  a_stable_bit: assert property (p_stable_bit) else $error("data bit changed while driven");
  property p_fell_oe;
    $fell(io_oe) && ce |-> $past(sclk, 2);
  endproperty
  a_fell_oe: assert property (p_fell_oe) else $error("line released without rising edge");
  property p_key_fields;
    charger_enable |-> charger_resistor != 2'b00;
  endproperty
  a_key_fields: assert property (p_key_fields) else $error("charger on with no resistor");
  property p_halt_commit;
    $changed(osc_running) |-> !ce && $past(ce, 2) == 1'b0;
  endproperty
  a_halt_commit: assert property (p_halt_commit) else $error("halt changed inside a transfer");
  property p_charger_commit;
    $changed({charger_enable, charger_two_diodes, charger_resistor}) |-> ce && $past(ce, 4);
  endproperty
  a_charger_commit: assert property (p_charger_commit) else $error("charger changed outside a write");

  c_read_bit: cover property ($rose(io_oe));
  c_charger_on: cover property ($rose(charger_enable));
  c_clock_runs: cover property ($rose(osc_running));
endmodule // rtc_port_checker

bind serial_rtc_ram_3wire rtc_port_checker u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .sclk(sclk), .io_in(io_in), .osc_in(osc_in),
  .io_out(io_out), .io_oe(io_oe), .charger_enable(charger_enable),
  .charger_two_diodes(charger_two_diodes), .charger_resistor(charger_resistor), .osc_running(osc_running)
);

// ### serial_rtc_ram_3wire_test.sv
// self-checking bench of the serial clock/ram block
`timescale 1ns/10ps
module serial_rtc_ram_3wire_test;
  logic        sys_clk;
  logic        reset_n;
  logic        osc_in;
  wire         ce;
  wire         sclk;
  wire         io_drv;
  wire         io_en;
  wire         io_line;
  wire         io_out;
  wire         io_oe;
  wire         charger_enable;
  wire         charger_two_diodes;
  wire  [1:0]  charger_resistor;
  wire         osc_running;
  int          failures;
  int          checks_done;
  int          cyc;
  logic [11:0] rows [0:7];

  // data line with its pull-down
  assign io_line = io_oe ? io_out : (io_en ? io_drv : 1'b0);

  serial_rtc_ram_3wire #(.OSC_DIV(4)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .sclk(sclk), .io_in(io_line), .osc_in(osc_in),
    .io_out(io_out), .io_oe(io_oe), .charger_enable(charger_enable),
    .charger_two_diodes(charger_two_diodes), .charger_resistor(charger_resistor), .osc_running(osc_running)
  );
  rtc_host_model u_host (.ce(ce), .sclk(sclk), .io_drv(io_drv), .io_en(io_en), .io_line(io_line));

  always #2.5 sys_clk = ~sys_clk;
  always begin
    repeat (40) @(posedge sys_clk);
    osc_in <= ~osc_in;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      failures++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] cmd, input int n, input logic [63:0] e);
    u_host.xfer(cmd, n, 64'h0);
    for (int k = 0; k < n; k++) chk($sformatf("read %h byte %0d", cmd, k), e[8*k +: 8], u_host.rx[8*k +: 8]);
  endtask
  task automatic chg(input logic [3:0] e);
    chk("charger", {4'h0, e}, {4'h0, charger_enable, charger_two_diodes, charger_resistor});
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    osc_in = 1'b0;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    // charger byte, then enable, two diodes, resistor
    rows[0] = 12'hA59;
    rows[1] = 12'hAAE;
    rows[2] = 12'hA7B;
    rows[3] = 12'hA9D;
    rows[4] = 12'hA40;
    rows[5] = 12'hAC0;
    rows[6] = 12'h551;
    rows[7] = 12'h5A6;
    repeat (12) @(posedge sys_clk);
    chk("reset flags", 8'h00, {5'h00, io_oe, charger_enable, osc_running});
    reset_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(8'h8F, 1, 64'h80);
    u_host.xfer(8'h90, 1, 64'hA5);
    chg(4'h0);
    u_host.xfer(8'h8E, 1, 64'h00);
    for (int i = 0; i < 8; i++) begin
      u_host.xfer(8'h90, 1, {56'h0, rows[i][11:4]});
      chg(rows[i][3:0]);
    end
    u_host.xfer(8'h10, 1, 64'hA5);
    chg(4'h6);
    u_host.xfer(8'hFE, 3, 64'h332211);
    u_host.xfer(8'hC2, 2, 64'hFF3C);
    rd(8'hFF, 3, 64'h333C11);
    rd(8'hC3, 2, 64'h3C3C);
    u_host.xfer(8'hBE, 8, 64'h0024070615235959);
    chk("running", 8'h01, {7'h00, osc_running});
    #2000;
    rd(8'hBF, 8, 64'h0024010616000000);
    u_host.xfer(8'h80, 1, 64'h80);
    chk("running", 8'h00, {7'h00, osc_running});
    u_host.xfer(8'hBE, 3, 64'h070605);
    rd(8'hBF, 2, 64'h0080);
    u_host.xfer(8'h8E, 1, 64'h80);
    u_host.xfer(8'hBE, 8, 64'h0);
    rd(8'hBF, 8, 64'h8024010616000080);
    u_host.xfer(8'hC0, 1, 64'h77);
    rd(8'hC1, 1, 64'h11);
    // 12-hour mode: 11:59:59 pm on the last day of february rolls to 12 am on the first of march
    u_host.xfer(8'h8E, 1, 64'h00);
    u_host.xfer(8'hBE, 8, 64'h0023030228B15959);
    #2000;
    rd(8'hBF, 8, 64'h0023040301920000);
    stop_test();
  end
endmodule // serial_rtc_ram_3wire_test
